// >>> dcas_defs.vh
// What this block does
// R1: Sample choice line on each serial falling edge; the code samples it only on the third fall.
// R2: Only third control bit from MSB counts.
// R3: Choice bit picks next conversion's input.
// R4: Control in and result out share frame.
// R5: One result bit per falling edge, no delay.
// R6: 12-bit: zeros, id, id copy, result MSB-first.
// R7: 10-bit: zeros, id, copy, result, two zeros.
// R8: Every result is one 16-bit frame.
// R9: Result code is straight unsigned binary.
// R10: Serial clock paces shifting and conversion.
// R11: Chip select fall samples and starts conversion.
// R12: Host gives 14 or 16 serial clocks.
// R13: Select rise after edge 10 aborts, releases output.
// R14: Host waits a quiet gap before next select.
// R15: Output released while chip select is high.
// R16: Select fall restarts the bit counter.
`ifndef DCAS_DEFS_VH
`define DCAS_DEFS_VH
`define DCAS_FRAME_BITS 16
`define DCAS_CHOICE_EDGE 5'h03
`define DCAS_HDR_BITS 4
`define DCAS_RES_DEFAULT 12
`endif

// >>> dcas_serial_port.v
`timescale 1ns/100ps
`include "dcas_defs.vh"
module dcas_serial_port #(
	parameter RES_BITS = `DCAS_RES_DEFAULT
) (
	// Clock and reset.
	input wire ref_clk_i,
	input wire reset_n_i,
	// Serial pins from the host, synchronous to ref_clk_i.
	input wire cs_n_i,
	input wire sclk_i,
	input wire input_choice_bit_i,
	// Serial result pin, two signals: data and output enable.
	output reg dout_o,
	output reg dout_oe_o,
	// Sample handoff to the analog front end.
	output reg sample_o,
	output reg sample_chan_o,
	// Converted code from the front end through a two-entry buffer.
	input wire code_valid_i,
	input wire [RES_BITS-1:0] code_i,
	output wire code_ready_o
);
	reg cs_d_reg;
	reg sclk_d_reg;
	reg [4:0] edge_cnt_reg;
	reg chan_next_reg;
	reg chan_cur_reg;
	reg active_reg;
	reg [RES_BITS-1:0] buf_data_reg [0:1];
	reg [1:0] buf_cnt_reg;
	reg buf_rd_reg;
	reg buf_wr_reg;
	reg [RES_BITS-1:0] res_reg;
	reg res_ok_reg;
	wire cs_fall;
	wire cs_rise;
	wire sclk_fall;
	wire [4:0] bit_idx;
	wire [4:0] res_pos;
	wire res_bit;
	wire buf_push;
	wire buf_pop;

	// Edge detection on the host pins, all already in this clock domain.
	assign cs_fall = cs_d_reg & ~cs_n_i; // R11
	assign cs_rise = ~cs_d_reg & cs_n_i;
	assign sclk_fall = sclk_d_reg & ~sclk_i & ~cs_n_i; // R10
	assign bit_idx = edge_cnt_reg;
	// Slot about to be shown, one past the current count, less the header.
	assign res_pos = bit_idx - 5'h03;

	// Buffer handshake; the front end stalls once both entries are held.
	assign code_ready_o = (buf_cnt_reg != 2'h2);
	assign buf_push = code_valid_i & code_ready_o;
	assign buf_pop = (buf_cnt_reg != 2'h0) & ~res_ok_reg & active_reg;

	// Result bit at the next frame slot; code sent as straight binary.
	assign res_bit = (res_pos < RES_BITS) ?
		res_reg[RES_BITS-1-res_pos] : 1'b0; // R9 R7

	// Serial framing and channel choice.
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cs_d_reg <= 1'b1;
			sclk_d_reg <= 1'b0;
			edge_cnt_reg <= 5'h00;
			chan_next_reg <= 1'b0;
			chan_cur_reg <= 1'b0;
			active_reg <= 1'b0;
			dout_o <= 1'b0;
			dout_oe_o <= 1'b0;
			sample_o <= 1'b0;
			sample_chan_o <= 1'b0;
		end else begin
			cs_d_reg <= cs_n_i;
			sclk_d_reg <= sclk_i;
			sample_o <= 1'b0;
			if (cs_fall) begin
				edge_cnt_reg <= 5'h00; // R16
				chan_cur_reg <= chan_next_reg; // R3
				sample_o <= 1'b1; // R11
				sample_chan_o <= chan_next_reg;
				active_reg <= 1'b1;
				dout_oe_o <= 1'b1;
				dout_o <= 1'b0; // R8
			end else if (cs_n_i) begin
				// Abort at any point; output released for sharing.
				active_reg <= 1'b0; // R13
				dout_oe_o <= 1'b0; // R15
				dout_o <= 1'b0;
			end else if (sclk_fall && active_reg) begin
				// Control sampled in the same edge that shifts result out.
				if (edge_cnt_reg == `DCAS_CHOICE_EDGE - 5'h01)
					chan_next_reg <= input_choice_bit_i; // R1 R2 R4
				if (edge_cnt_reg == 5'd`DCAS_FRAME_BITS - 5'h01) begin
					active_reg <= 1'b0;
					dout_oe_o <= 1'b0;
					dout_o <= 1'b0;
				end else begin
					edge_cnt_reg <= edge_cnt_reg + 5'h01; // R5
					case (edge_cnt_reg + 5'h01)
						5'h01: dout_o <= 1'b0; // R6 R8
						5'h02: dout_o <= chan_cur_reg; // R6 R7
						5'h03: dout_o <= chan_cur_reg;
						// Slots sent before a code is loaded in this frame go out as zeros.
						default: dout_o <= res_ok_reg & res_bit; // R9 R7
					endcase
				end
			end
		end
	end

	// Two-entry code buffer and the result being shifted.
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			buf_data_reg[0] <= {RES_BITS{1'b0}};
			buf_data_reg[1] <= {RES_BITS{1'b0}};
			buf_cnt_reg <= 2'h0;
			buf_rd_reg <= 1'b0;
			buf_wr_reg <= 1'b0;
			res_reg <= {RES_BITS{1'b0}};
			res_ok_reg <= 1'b0;
		end else begin
			if (buf_push) begin
				buf_data_reg[buf_wr_reg] <= code_i;
				buf_wr_reg <= ~buf_wr_reg;
			end
			if (buf_pop) begin
				res_reg <= buf_data_reg[buf_rd_reg];
				buf_rd_reg <= ~buf_rd_reg;
			end
			if (cs_fall || !active_reg)
				res_ok_reg <= 1'b0;
			else if (buf_pop)
				res_ok_reg <= 1'b1;
			buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} -
				{1'b0, buf_pop};
		end
	end
endmodule

// >>> dcas_serial_port_sva.sv
`timescale 1ns/100ps
module dcas_serial_port_sva (
	input wire ref_clk_i, reset_n_i, cs_n_i, sclk_i,
	input wire dout_o, dout_oe_o, sample_o, sample_chan_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	reg s_reg;
	reg [4:0] n_reg;
	wire fall = s_reg & !sclk_i;
	// Falls seen in this frame, held at 16 so the count cannot wrap.
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_reg <= 1'h0;
			n_reg <= 5'h00;
		end else begin
			s_reg <= sclk_i;
			n_reg <= cs_n_i ? 5'h00 : n_reg + (fall && n_reg < 5'h10);
		end
	end
	sequence open_s; $rose(dout_oe_o); endsequence
	oe_release_a: assert property (cs_n_i [*3] |-> !dout_oe_o)
		else $error("output driven while deselected");
	oe_open_a: assert property (open_s |-> sample_o && !dout_o)
		else $error("output opened without a sample");
	pulse_once_a: assert property (sample_o |=> !sample_o)
		else $error("sample pulse too long");
	sample_cs_a: assert property ($fell(cs_n_i) |-> ##[1:2] sample_o)
		else $error("no sample after select");
	lead_zero_a: assert property (dout_oe_o && n_reg < 5'h02 |-> !dout_o)
		else $error("leading bit not zero");
	id_copy_a: assert property (dout_oe_o && n_reg == 5'h03 |->
		dout_o == sample_chan_o)
		else $error("channel bit wrong");
	stop_a: assert property (n_reg == 5'h10 |-> ##3 !dout_oe_o)
		else $error("output still driven after frame");
	hold_a: assert property ($changed(dout_o) && $past(dout_oe_o) |->
		$past(fall) || $past(fall, 2))
		else $error("output moved without a clock fall");
endmodule
bind dcas_serial_port dcas_serial_port_sva dcas_serial_port_sva_i (
	.ref_clk_i, .reset_n_i, .cs_n_i, .sclk_i,
	.dout_o, .dout_oe_o, .sample_o, .sample_chan_o);

// >>> dcas_host_model.sv
`timescale 1ns/100ps
module dcas_host_model (
	input wire ref_clk_i, input wire dout_i,
	output reg cs_n_o, output reg sclk_o, output reg choice_o
);
	// Idle deselected with the serial clock parked, not running free.
	initial begin
		cs_n_o = 1'h1;
		sclk_o = 1'h1;
		choice_o = 1'h0;
	end
	// One frame; the choice bit rides the third fall, the rest toggle.
	task frame(input c, input [4:0] nf, output [15:0] w);
		integer i;
		begin
			@(negedge ref_clk_i) cs_n_o = 1'h0;
			for (i = 0; i < nf; i = i + 1) begin
				repeat (3) @(negedge ref_clk_i);
				w[15 - i] = dout_i;
				choice_o = (i == 2) ? c : ~choice_o;
				sclk_o = 1'h0;
				repeat (3) @(negedge ref_clk_i);
				sclk_o = 1'h1;
			end
			repeat (3) @(negedge ref_clk_i) cs_n_o = 1'h1;
			repeat (4) @(negedge ref_clk_i);
		end
	endtask
endmodule

// >>> dcas_serial_port_tb.sv
`timescale 1ns/100ps
module dcas_serial_port_tb;
	reg ref_clk_i = 0, reset_n_i = 0, code_valid_i = 0, c, prev = 0;
	reg [11:0] code_i = 0, cd;
	reg [15:0] w;
	wire cs_n_i, sclk_i, input_choice_bit_i, dout_o, dout_oe_o;
	wire sample_o, sample_chan_o, code_ready_o;
	integer seed = 32'h349f, n_mismatch = 0, compares = 0, cyc = 0, k;
	always #50 ref_clk_i = ~ref_clk_i;
	dcas_serial_port #(.RES_BITS(12)) dcas_serial_port_i (.ref_clk_i,
		.reset_n_i, .cs_n_i, .sclk_i, .input_choice_bit_i, .dout_o,
		.dout_oe_o, .sample_o, .sample_chan_o, .code_valid_i, .code_i,
		.code_ready_o);
	dcas_host_model dcas_host_model_i (.ref_clk_i, .dout_i(dout_o),
		.cs_n_o(cs_n_i), .sclk_o(sclk_i), .choice_o(input_choice_bit_i));
	// Expected word: two zeros, channel twice, code MSB first.
	function [15:0] exp_w(input id, input [11:0] v);
		exp_w = {2'b00, id, id, v};
	endfunction
	task chk(input [15:0] g, input [15:0] e);
		begin
			compares = compares + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("mismatch %0t got %h", $time, g);
			end
		end
	endtask
	task finish_test;
		begin
			$display("mismatches %0d compares %0d", n_mismatch, compares);
			if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
			else $display("STATUS NOT OK");
			$finish;
		end
	endtask
	// A hang is cut short well past the expected run length.
	always @(posedge ref_clk_i) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			n_mismatch = n_mismatch + 1;
			finish_test;
		end
	end
	// Frames with random codes; all-zero and all-one codes come first.
	initial begin
		repeat (8) @(negedge ref_clk_i);
		reset_n_i = 1;
		for (k = 0; k < 20; k = k + 1) begin
			cd = k < 2 ? {12{k[0]}} : $random(seed);
			c = $random(seed);
			@(negedge ref_clk_i) code_valid_i = 1;
			code_i = cd;
			while (code_ready_o !== 1'b1) @(negedge ref_clk_i);
			@(negedge ref_clk_i) code_valid_i = 0;
			dcas_host_model_i.frame(c, 5'h10, w);
			chk(w, exp_w(prev, cd));
			if (k > 0) chk(sample_chan_o, prev);
			chk(dout_oe_o, 0);
			prev = c;
			$display("frame %0d done", k);
		end
		dcas_host_model_i.frame(c, 5'h0c, w);
		chk({w[15:4], 4'h0}, exp_w(prev, 12'h000));
		chk(dout_oe_o, 0);
		finish_test;
	end
endmodule
